// *** shared/sebs_consts.vh ***
// constants for the two-wire eeprom bus slave front end
// assumes inclusion by bare name from the core design file
`ifndef SEBS_CONSTS_VH
`define SEBS_CONSTS_VH
// upper four bits of the select byte (value arbitrary, set per build)
`define SEBS_TYPE_CODE      4'h5
`define SEBS_TYPE_MSB       7
`define SEBS_TYPE_LSB       4
`define SEBS_CS_MSB         3
`define SEBS_CS_LSB         1
`define SEBS_RW_BIT         0
`define SEBS_RW_READ        1'b1
`define SEBS_PAGE_BYTES     32
`define SEBS_ADDR_W         13
`define SEBS_MEM_WORDS      8192
`define SEBS_PROG_NS        5000000
`define SEBS_CLK_NS         100
`endif

// *** core/sebs_slave.v ***
// two-wire bus slave front end of a byte-organised serial eeprom
// assumes scl/sda sampled from pins; por_active_in from a supply monitor
`timescale 1ns/1ns
`include "sebs_consts.vh"
module sebs_slave #(
  parameter ADDR_W    = `SEBS_ADDR_W,
  parameter MEM_WORDS = `SEBS_MEM_WORDS,
  parameter PROG_CYC  = `SEBS_PROG_NS / `SEBS_CLK_NS
) (
  input  wire       clock_in,
  input  wire       rst_in,
  input  wire       por_active_in,
  input  wire       scl_in,
  input  wire       sda_in,
  input  wire [2:0] chip_select_pins_in,
  input  wire       array_write_inhibit_in,
  output reg        sda_out,
  output reg        sda_oe_out,
  output reg        prog_busy_out
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_SEL  = 6'h02;
  localparam [5:0] ST_AHI  = 6'h04;
  localparam [5:0] ST_ALO  = 6'h08;
  localparam [5:0] ST_WR   = 6'h10;
  localparam [5:0] ST_RD   = 6'h20;
  localparam       PAGE_W  = 5;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [1:0] scl_sync_reg;
  reg [1:0] sda_sync_reg;
  reg [1:0] por_sync_reg;
  reg [1:0] wc_sync_reg;
  reg [2:0] cs_m_reg;
  reg [2:0] cs_reg;
  reg       scl_d_reg;
  reg       sda_d_reg;
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      por_sync_reg <= 2'h3;
      wc_sync_reg  <= 2'h0;
      cs_m_reg     <= 3'h0;
      cs_reg       <= 3'h0;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      por_sync_reg <= {por_sync_reg[0], por_active_in};
      wc_sync_reg  <= {wc_sync_reg[0], array_write_inhibit_in};
      cs_m_reg     <= chip_select_pins_in;
      cs_reg       <= cs_m_reg;
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
    end
  end
  wire scl_s   = scl_sync_reg[1];
  wire sda_s   = sda_sync_reg[1];
  wire por     = por_sync_reg[1];
  wire wc      = wc_sync_reg[1];
  wire scl_re  = scl_s & ~scl_d_reg;
  wire scl_fe  = ~scl_s & scl_d_reg;
  wire start_c = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_c  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ----------------------------------------------------------------
  // storage and page buffer
  // ----------------------------------------------------------------
  reg [7:0]        mem [0:MEM_WORDS-1];
  reg [7:0]        page_buf [0:`SEBS_PAGE_BYTES-1];
  reg [`SEBS_PAGE_BYTES-1:0] page_vld_reg;

  reg [5:0]        state_reg;
  reg [3:0]        bit_reg;
  reg [7:0]        shift_reg;
  reg              ack_slot_reg;
  reg              rd_nack_reg;
  reg              mst_slot_reg;
  reg [ADDR_W-1:0] addr_reg;
  reg [ADDR_W-1:0] row_reg;
  reg              wc_lat_reg;
  reg              wr_pend_reg;
  reg [31:0]       prog_cnt_reg;

  wire [31:0]       mem_last = MEM_WORDS - 1;
  wire [ADDR_W-1:0] mem_top  = mem_last[ADDR_W-1:0];
  wire [PAGE_W-1:0] col      = addr_reg[PAGE_W-1:0];
  // whole byte as it stands at the eighth rising edge
  wire [7:0]        in_byte  = {shift_reg[6:0], sda_s};
  wire              sel_ok   =
    in_byte[`SEBS_TYPE_MSB:`SEBS_TYPE_LSB] == `SEBS_TYPE_CODE &&
    in_byte[`SEBS_CS_MSB:`SEBS_CS_LSB] == cs_reg;
  wire              byte_done = scl_re & ~ack_slot_reg & (bit_reg == 4'h7);
  wire [7:0]        rd_byte   = mem[addr_reg];

  // ----------------------------------------------------------------
  // programming cycle
  // ----------------------------------------------------------------
  integer i;
  always @(posedge clock_in) begin
    if (prog_busy_out && prog_cnt_reg == 32'h0) begin
      for (i = 0; i < `SEBS_PAGE_BYTES; i = i + 1) begin
        // top quarter kept when inhibit was high
        if (page_vld_reg[i] &&
            !(wc_lat_reg && row_reg[ADDR_W-1:ADDR_W-2] == 2'h3))
          mem[{row_reg[ADDR_W-1:PAGE_W], i[PAGE_W-1:0]}] <= page_buf[i];
      end
    end
    if (state_reg == ST_WR && byte_done)
      page_buf[col] <= {shift_reg[6:0], sda_s};
  end

  // ----------------------------------------------------------------
  // bus protocol engine
  // ----------------------------------------------------------------
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg     <= ST_IDLE;
      bit_reg       <= 4'h0;
      shift_reg     <= 8'h00;
      ack_slot_reg  <= 1'b0;
      rd_nack_reg   <= 1'b0;
      mst_slot_reg  <= 1'b0;
      addr_reg      <= {ADDR_W{1'b0}};
      row_reg       <= {ADDR_W{1'b0}};
      wc_lat_reg    <= 1'b0;
      wr_pend_reg   <= 1'b0;
      page_vld_reg  <= {`SEBS_PAGE_BYTES{1'b0}};
      prog_cnt_reg  <= 32'h0;
      prog_busy_out <= 1'b0;
      sda_out       <= 1'b0;
      sda_oe_out    <= 1'b0;
    end else if (por) begin
      state_reg    <= ST_IDLE;
      sda_oe_out   <= 1'b0;
      wr_pend_reg  <= 1'b0;
      page_vld_reg <= {`SEBS_PAGE_BYTES{1'b0}};
    end else if (prog_busy_out) begin
      sda_oe_out <= 1'b0;
      if (prog_cnt_reg == 32'h0) begin
        prog_busy_out <= 1'b0;
        page_vld_reg  <= {`SEBS_PAGE_BYTES{1'b0}};
      end else
        prog_cnt_reg <= prog_cnt_reg - 32'h1;
    end else if (start_c) begin
      state_reg    <= ST_SEL;
      bit_reg      <= 4'h0;
      ack_slot_reg <= 1'b0;
      sda_oe_out   <= 1'b0;
      wr_pend_reg  <= 1'b0;
      page_vld_reg <= {`SEBS_PAGE_BYTES{1'b0}};
      wc_lat_reg   <= wc;
    end else if (stop_c) begin
      state_reg  <= ST_IDLE;
      sda_oe_out <= 1'b0;
      if (wr_pend_reg) begin
        prog_busy_out <= 1'b1;
        prog_cnt_reg  <= PROG_CYC - 1;
        wr_pend_reg   <= 1'b0;
      end
    end else if (state_reg != ST_IDLE) begin
      if (scl_re && !ack_slot_reg) begin
        shift_reg <= {shift_reg[6:0], sda_s};
        bit_reg   <= bit_reg + 4'h1;
        if (state_reg == ST_AHI || state_reg == ST_ALO)
          wc_lat_reg <= wc_lat_reg | wc;
      end
      if (byte_done) begin
        ack_slot_reg <= 1'b1;
        bit_reg      <= 4'h0;
        // a byte sent by us is acknowledged by the master
        mst_slot_reg <= (state_reg == ST_RD);
        case (state_reg)
          ST_SEL: begin
            if (!sel_ok)
              state_reg <= ST_IDLE;
            else if (in_byte[`SEBS_RW_BIT] == `SEBS_RW_READ)
              state_reg <= ST_RD;
            else
              state_reg <= ST_AHI;
          end
          ST_AHI: begin
            addr_reg[ADDR_W-1:8] <= in_byte[ADDR_W-9:0];
            state_reg            <= ST_ALO;
          end
          ST_ALO: begin
            addr_reg[7:0] <= {shift_reg[6:0], sda_s};
            row_reg       <= {addr_reg[ADDR_W-1:8],
                              shift_reg[6:0], sda_s};
            state_reg     <= ST_WR;
          end
          ST_WR: begin
            page_vld_reg[col] <= 1'b1;
            wr_pend_reg       <= 1'b1;
            // roll over inside the row
            addr_reg[PAGE_W-1:0] <= col + 5'h01;
          end
          ST_RD: begin
            addr_reg    <= (addr_reg == mem_top) ?
                           {ADDR_W{1'b0}} :
                           addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
      // ninth slot: bit_reg 0 before its rising edge, 8 after it
      if (scl_re && ack_slot_reg) begin
        bit_reg <= 4'h8;
        if (mst_slot_reg)
          rd_nack_reg <= sda_s;
      end
      if (scl_fe && ack_slot_reg && bit_reg == 4'h0) begin
        // slot opens: pull low for a received byte, else let go
        sda_oe_out <= ~mst_slot_reg;
      end else if (scl_fe && ack_slot_reg) begin
        ack_slot_reg <= 1'b0;
        bit_reg      <= 4'h0;
        if (state_reg == ST_RD && !(mst_slot_reg && rd_nack_reg))
          sda_oe_out <= ~rd_byte[7];
        else begin
          sda_oe_out <= 1'b0;
          if (state_reg == ST_RD)
            state_reg <= ST_IDLE;
        end
      end else if (scl_fe && state_reg == ST_RD) begin
        sda_oe_out <= ~rd_byte[3'h7 - bit_reg[2:0]];
      end
    end
  end
endmodule // sebs_slave

// *** tb/sebs_monitor.sv ***
// checker on the ports of the two-wire eeprom bus slave
// assumes bus lines are seen through the system clock only
`timescale 1ns/1ns
`include "sebs_consts.vh"
module sebs_monitor #(
  parameter ADDR_W    = 13,
  parameter MEM_WORDS = 8192,
  parameter PROG_CYC  = 50000
) (
  input wire       clock_in,
  input wire       rst_in,
  input wire       por_active_in,
  input wire       scl_in,
  input wire       sda_in,
  input wire [2:0] chip_select_pins_in,
  input wire       array_write_inhibit_in,
  input wire       sda_out,
  input wire       sda_oe_out,
  input wire       prog_busy_out
);
  reg       scl_q, sda_q;
  reg [3:0] n, ss;
  reg [7:0] sh;
  integer   bc;
  wire st = scl_in & scl_q & sda_q & ~sda_in;
  wire sp = scl_in & scl_q & ~sda_q & sda_in;
  wire ty = sh[7:4] == `SEBS_TYPE_CODE;
  wire cs = sh[3:1] == chip_select_pins_in;
  // select byte tracker: n counts bits after a start, sticks at 9
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      n     <= 4'h9;
      ss    <= 4'hf;
      sh    <= 8'h00;
      bc    <= 0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      ss <= sp ? 4'h0 : (ss == 4'hf ? ss : ss + 4'h1);
      bc <= prog_busy_out ? bc + 1 : 0;
      if (st) n <= 4'h0;
      else if (scl_in & ~scl_q & (n < 4'h9)) begin
        n <= n + 4'h1;
        sh <= {sh[6:0], sda_in};
      end
    end
  end
  default clocking @(posedge clock_in); endclocking
  sequence sel_end; $fell(scl_in) && n == 4'h8 && ty && cs && !prog_busy_out;
  endsequence
  sequence ack_due; ##[1:5] sda_oe_out; endsequence
  drain_only_a: assert property (disable iff (rst_in) !sda_out)
    else $error("data line driven high");
  por_quiet_a: assert property (disable iff (rst_in)
    por_active_in [*5] |-> !sda_oe_out) else $error("ack under lock-out");
  busy_quiet_a: assert property (disable iff (rst_in)
    prog_busy_out |-> !sda_oe_out) else $error("ack while programming");
  busy_len_a: assert property (disable iff (rst_in || por_active_in)
    $fell(prog_busy_out) |-> bc == PROG_CYC) else $error("program length");
  prog_stop_a: assert property (disable iff (rst_in)
    $rose(prog_busy_out) |-> ss < 4'h8) else $error("program without stop");
  launch_low_a: assert property (disable iff (rst_in || por_active_in)
    $changed(sda_oe_out) |-> !scl_in) else $error("data moved, clock high");
  type_gate_a: assert property (disable iff (rst_in)
    n == 4'h8 && !ty |-> !sda_oe_out) else $error("ack on wrong type");
  cs_gate_a: assert property (disable iff (rst_in)
    n == 4'h8 && !cs |-> !sda_oe_out) else $error("ack on wrong select");
  ack_slot_a: assert property (disable iff (rst_in || por_active_in)
    sel_end |-> ack_due) else $error("select not acknowledged");
endmodule // sebs_monitor
bind sebs_slave sebs_monitor #(.ADDR_W(ADDR_W), .MEM_WORDS(MEM_WORDS),
  .PROG_CYC(PROG_CYC)) u_sebs_monitor (.clock_in(clock_in), .rst_in(rst_in),
  .por_active_in(por_active_in), .scl_in(scl_in), .sda_in(sda_in),
  .chip_select_pins_in(chip_select_pins_in), .sda_out(sda_out),
  .array_write_inhibit_in(array_write_inhibit_in),
  .sda_oe_out(sda_oe_out), .prog_busy_out(prog_busy_out));

// *** tb/sebs_master_model.sv ***
// bus master model: makes the bus clock and drives data open drain
// assumes the data wire is resolved outside with a pull-up
`timescale 1ns/1ns
module sebs_master_model (
  input  wire clock_in,
  input  wire sda_in,
  output reg  scl_out,
  output reg  sda_oe_out
);
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  task q; repeat (2) @(negedge clock_in); endtask
  // data moves mid-low except for the start and stop edges; clock stands high between frames
  task start;
    begin
      q;
      sda_oe_out = 1'b0;
      q;
      scl_out = 1'b1;
      q;
      sda_oe_out = 1'b1;
      q;
      scl_out = 1'b0;
    end
  endtask
  task stop;
    begin
      q;
      sda_oe_out = 1'b1;
      q;
      scl_out = 1'b1;
      q;
      sda_oe_out = 1'b0;
      q;
    end
  endtask
  task clk_bit(input b, output r);
    begin
      q;
      sda_oe_out = ~b;
      q;
      scl_out = 1'b1;
      q;
      r = sda_in;
      q;
      scl_out = 1'b0;
    end
  endtask
  task xfer(input [7:0] tx, input ackb, output [7:0] rx, output ack);
    integer i;
    reg     r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        clk_bit(tx[i], r);
        rx[i] = r;
      end
      clk_bit(ackb, r);
      ack = ~r;
    end
  endtask
endmodule // sebs_master_model

// *** tb/sebs_slave_tb.sv ***
// self-checking bench for the two-wire eeprom bus slave
// assumes the master model and the bound port checker
`timescale 1ns/1ns
`include "sebs_consts.vh"
module sebs_slave_tb;
  localparam [7:0] SW = {`SEBS_TYPE_CODE, 3'h5, 1'b0};
  reg       clock_in = 1'b0, rst_in = 1'b1, por = 1'b0, inh = 1'b0, ack;
  reg [7:0] rx;
  reg [8:0] rows [0:3];
  reg [2:0] cs_pins = 3'h5;
  wire      scl, m_oe, s_out, s_oe, busy;
  wire      sda = (s_oe ? s_out : 1'b1) & ~m_oe;
  integer   num_errors = 0, checks = 0, cyc = 0, i;
  always #50 clock_in = ~clock_in;
  sebs_slave #(.PROG_CYC(200)) u_sebs_slave (.clock_in(clock_in),
    .rst_in(rst_in), .por_active_in(por), .scl_in(scl), .sda_in(sda),
    .chip_select_pins_in(cs_pins), .array_write_inhibit_in(inh),
    .sda_out(s_out), .sda_oe_out(s_oe), .prog_busy_out(busy));
  sebs_master_model u_sebs_master_model (.clock_in(clock_in),
    .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));
  // ----
  // checking and closing
  // ----
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task finish_test;
    begin
      if (num_errors == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  always @(posedge clock_in) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      finish_test;
    end
  end
  task xb(input [7:0] tx, input ackb, input exp_ack);
    begin
      u_sebs_master_model.xfer(tx, ackb, rx, ack);
      chk(ack, exp_ack);
    end
  endtask
  task wt(input v);
    integer k;
    begin
      for (k = 0; busy !== v && k < 400; k = k + 1) @(negedge clock_in);
      chk(busy, v);
    end
  endtask
  task wr(input [15:0] a, input [7:0] d0, input [7:0] d1);
    begin
      u_sebs_master_model.start;
      xb(SW, 1'b1, 1'b1);
      xb(a[15:8], 1'b1, 1'b1);
      xb(a[7:0], 1'b1, 1'b1);
      xb(d0, 1'b1, 1'b1);
      xb(d1, 1'b1, 1'b1);
      u_sebs_master_model.stop;
      wt(1'b1);
      u_sebs_master_model.start;
      xb(SW, 1'b1, 1'b0);
      u_sebs_master_model.stop;
      wt(1'b0);
    end
  endtask
  task rd(input [15:0] a, input [7:0] e0, input [7:0] e1);
    begin
      u_sebs_master_model.start;
      xb(SW, 1'b1, 1'b1);
      xb(a[15:8], 1'b1, 1'b1);
      xb(a[7:0], 1'b1, 1'b1);
      u_sebs_master_model.start;
      xb(SW | 8'h01, 1'b1, 1'b1);
      u_sebs_master_model.xfer(8'hff, 1'b0, rx, ack);
      chk(rx, e0);
      u_sebs_master_model.xfer(8'hff, 1'b1, rx, ack);
      chk(rx, e1);
      u_sebs_master_model.stop;
    end
  endtask
  initial begin
    rows[0] = {SW, 1'b1};
    rows[1] = {SW ^ 8'h80, 1'b0};
    rows[2] = {SW ^ 8'h04, 1'b0};
    rows[3] = {SW ^ 8'h0e, 1'b0};
    repeat (3) @(negedge clock_in);
    rst_in = 1'b0;
    chk({s_out, s_oe, busy}, 16'h0000);
    for (i = 0; i < 4; i = i + 1) begin
      u_sebs_master_model.start;
      xb(rows[i][8:1], 1'b1, rows[i][0]);
      u_sebs_master_model.stop;
    end
    // other strap: old select code refused, new one taken
    cs_pins = 3'h2;
    u_sebs_master_model.start;
    xb(SW, 1'b1, 1'b0);
    u_sebs_master_model.stop;
    u_sebs_master_model.start;
    xb({`SEBS_TYPE_CODE, 3'h2, 1'b0}, 1'b1, 1'b1);
    u_sebs_master_model.stop;
    cs_pins = 3'h5;
    wr(16'h0010, 8'ha5, 8'h3c);
    rd(16'h0010, 8'ha5, 8'h3c);
    wr(16'h1ffe, 8'h11, 8'h22);
    inh = 1'b1;
    wr(16'h1ffe, 8'h33, 8'h44);
    inh = 1'b0;
    rd(16'h1ffe, 8'h11, 8'h22);
    por = 1'b1;
    u_sebs_master_model.start;
    xb(SW, 1'b1, 1'b0);
    u_sebs_master_model.stop;
    por = 1'b0;
    finish_test;
  end
endmodule // sebs_slave_tb
